// ===== power_control_pkg.sv
// Package: register map, field layout, reset values and timing counts of the power control block.
package power_control_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] POWER_CONTROL_ONE_OFFSET       = 8'h00;
    localparam logic [7:0] VOLTAGE_MONITOR_CONTROL_OFFSET = 8'h04;
    localparam logic [7:0] POWER_STATUS_OFFSET            = 8'h14;

    localparam logic [31:0] POWER_CONTROL_ONE_RESET       = 32'h00000000;
    localparam logic [31:0] VOLTAGE_MONITOR_CONTROL_RESET = 32'h00000500;
    localparam logic [31:0] POWER_CONTROL_ONE_MASK        = 32'h00087700;
    localparam logic [31:0] VOLTAGE_MONITOR_CONTROL_MASK  = 32'h00000F75;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int STOP_WAKE_OSC_TIMING_BIT  = 19;
    localparam int STOP_LP_REGULATOR_BIT     = 14;
    localparam int FLASH_WAKE_WAIT_LSB       = 12;
    localparam int STOP_CORE_VOLTAGE_LSB     = 9;
    localparam int RTC_ACCESS_UNLOCK_BIT     = 8;
    localparam int MONITOR_FILTER_LENGTH_LSB = 9;
    localparam int MONITOR_FILTER_ENABLE_BIT = 8;
    localparam int MONITOR_THRESHOLD_LSB     = 4;
    localparam int MONITOR_SOURCE_BIT        = 2;
    localparam int MONITOR_ENABLE_BIT        = 0;
    localparam int MONITOR_RESULT_BIT        = 11;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int FLASH_WAIT_1_NS = 1000;
    localparam int FLASH_WAIT_2_NS = 2000;
    localparam int FLASH_WAIT_3_NS = 3000;
    localparam logic [7:0] FLASH_WAIT_1_CYCLES =
        8'((FLASH_WAIT_1_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
    localparam logic [7:0] FLASH_WAIT_2_CYCLES =
        8'((FLASH_WAIT_2_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
    localparam logic [7:0] FLASH_WAIT_3_CYCLES =
        8'((FLASH_WAIT_3_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
    localparam logic [10:0] FILTER_LONGEST = 11'h400;

    // Stop wake-up sequencer states.
    typedef enum logic [2:0] {
        SEQ_RUN        = 3'b000,
        SEQ_STOP       = 3'b001,
        SEQ_REGULATOR  = 3'b010,
        SEQ_OSCILLATOR = 3'b011,
        SEQ_FLASH_WAIT = 3'b100
    } wake_state_t;

    // Analog control bundle driven to the regulator and oscillator.
    typedef struct packed {
        logic       low_power_regulator;
        logic [1:0] core_voltage;
        logic       fast_osc_enable;
        logic       main_regulator_to_active;
    } analog_ctrl_t;

    // Monitor comparator configuration bundle.
    typedef struct packed {
        logic       enable;
        logic       source_pin;
        logic [2:0] threshold;
    } monitor_cfg_t;

endpackage

// ===== power_control_voltage_monitor.sv
// Power control registers, stop wake-up sequencer and supply voltage monitor filter.
//
// Contract
// [R1] Half-word and word register accesses accepted.
// [R2] Oscillator waits regulator unless immediate bit set.
// [R3] Stop regulator choice follows regulator select bit.
// [R4] Flash wait after oscillator: 1,2,3,0 us.
// [R5] Software avoids flash 3us when wait zero.
// [R6] Stop core voltage from voltage select field.
// [R7] RTC access blocked until unlock bit set.
// [R8] First register clears only on power-on reset.
// [R9] Filter length codes map to slow-clock counts.
// [R10] Filter applied only when filter enable set.
// [R11] Threshold field picks one of eight levels.
// [R12] Source bit selects supply or external pin.
// [R13] Detection runs only while monitor enable set.
// [R14] Lock blocks enable writes; system reset clears.
// [R15] Second register resets 0x500 on power-on only.
// [R16] Status bit 11 reports monitor result.
// [R17] Wake delay sums regulator, oscillator, flash waits.
// [R18] Filtered result changes after stable run.
// [R19] Code 111 treated as 1024 cycles.
// [R20] Reserved bits read zero, ignore writes.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module power_control_voltage_monitor (
    input  wire logic                            mclk,
    input  wire logic                            rst,
    input  wire logic                            por_rst,
    input  wire logic                            hsel,
    input  wire logic [7:0]                      haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    input  wire logic [2:0]                      hsize,
    input  wire logic [31:0]                     hwdata,
    input  wire logic                            hready,
    output logic      [31:0]                     hrdata,
    output logic                                 hreadyout,
    output logic                                 hresp,
    input  wire logic                            monitor_enable_lock,
    input  wire logic                            stop_request,
    input  wire logic                            wake_request,
    input  wire logic                            main_regulator_ready,
    input  wire logic                            fast_osc_ready,
    input  wire logic                            slow_clock_tick,
    input  wire logic                            monitor_raw,
    output power_control_pkg::analog_ctrl_t      analog_ctrl,
    output power_control_pkg::monitor_cfg_t      monitor_cfg,
    output logic                                 flash_access_allowed,
    output logic                                 rtc_access_allowed,
    output logic                                 stop_active,
    output logic                                 wake_done
);

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic [31:0] ctrl_one_reg;
    logic [31:0] ctrl_one_next;
    logic [31:0] mon_ctrl_reg;
    logic [31:0] mon_ctrl_next;
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic [1:0]  wr_size_reg;
    logic [1:0]  wr_lane_reg;
    logic        monitor_result_reg;
    logic        filter_last_reg;
    logic [10:0] filter_count_reg;
    logic [31:0] rdata_reg;

    wire         phase_valid = hsel && hready && htrans[1];
    wire         size_ok     = (hsize == 3'h1) || (hsize == 3'h2); // R1
    wire  [31:0] lane_mask   = (wr_size_reg == 2'h2) ? 32'hFFFFFFFF :
                               (wr_lane_reg[1] ? 32'hFFFF0000 : 32'h0000FFFF);
    wire         wr_one      = wr_pend_reg &&
                               (wr_addr_reg == power_control_pkg::POWER_CONTROL_ONE_OFFSET);
    wire         wr_mon      = wr_pend_reg &&
                               (wr_addr_reg == power_control_pkg::VOLTAGE_MONITOR_CONTROL_OFFSET);
    wire  [31:0] one_wmask   = lane_mask & power_control_pkg::POWER_CONTROL_ONE_MASK; // R20
    wire  [31:0] mon_wmask_a = lane_mask & power_control_pkg::VOLTAGE_MONITOR_CONTROL_MASK;
    // A set lock freezes the enable bit against software writes.
    wire  [31:0] mon_wmask   = monitor_enable_lock ?
        (mon_wmask_a & ~(32'h1 << power_control_pkg::MONITOR_ENABLE_BIT)) : mon_wmask_a; // R14

    // Byte-enable style merge: only the written lanes of writable bits change.
    assign ctrl_one_next = wr_one ? ((ctrl_one_reg & ~one_wmask) | (hwdata & one_wmask))
                                  : ctrl_one_reg;
    assign mon_ctrl_next = wr_mon ? ((mon_ctrl_reg & ~mon_wmask) | (hwdata & mon_wmask))
                                  : mon_ctrl_reg;

    // Read mux; any size returns the whole aligned word, unmapped addresses read zero.
    wire  [7:0]  rd_addr     = {haddr[7:2], 2'b00}; // R1
    wire  [31:0] status_word = {20'h0, monitor_result_reg, 11'h0}; // R16
    wire  [31:0] read_word   =
        (rd_addr == power_control_pkg::POWER_CONTROL_ONE_OFFSET)       ? ctrl_one_reg :
        (rd_addr == power_control_pkg::VOLTAGE_MONITOR_CONTROL_OFFSET) ? mon_ctrl_reg :
        (rd_addr == power_control_pkg::POWER_STATUS_OFFSET)            ? status_word  : 32'h0;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;

    // Capture the address phase so the write lands in the data phase.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_size_reg <= 2'h0;
            wr_lane_reg <= 2'h0;
            rdata_reg   <= 32'h0;
        end else begin
            wr_pend_reg <= phase_valid && hwrite && size_ok;
            wr_addr_reg <= {haddr[7:2], 2'b00};
            wr_size_reg <= hsize[1:0];
            wr_lane_reg <= haddr[1:0];
            if (phase_valid && !hwrite) begin
                rdata_reg <= read_word;
            end
        end
    end

    // Control registers are held through system reset; only power-on resets them.
    always_ff @(posedge mclk) begin
        if (por_rst) begin
            ctrl_one_reg <= power_control_pkg::POWER_CONTROL_ONE_RESET;       // R8
            mon_ctrl_reg <= power_control_pkg::VOLTAGE_MONITOR_CONTROL_RESET; // R15
        end else begin
            ctrl_one_reg <= ctrl_one_next;
            mon_ctrl_reg <= mon_ctrl_next;
        end
    end

    // ************************************************************
    // Field decode
    // ************************************************************
    wire       osc_immediate = ctrl_one_reg[power_control_pkg::STOP_WAKE_OSC_TIMING_BIT];
    wire       lp_regulator  = ctrl_one_reg[power_control_pkg::STOP_LP_REGULATOR_BIT];
    wire [1:0] flash_wait    = ctrl_one_reg[power_control_pkg::FLASH_WAKE_WAIT_LSB +: 2];
    wire [1:0] core_voltage  = ctrl_one_reg[power_control_pkg::STOP_CORE_VOLTAGE_LSB +: 2];
    wire [2:0] filt_code     = mon_ctrl_reg[power_control_pkg::MONITOR_FILTER_LENGTH_LSB +: 3];
    wire       filt_enable   = mon_ctrl_reg[power_control_pkg::MONITOR_FILTER_ENABLE_BIT];
    wire       mon_enable    = mon_ctrl_reg[power_control_pkg::MONITOR_ENABLE_BIT];

    assign rtc_access_allowed = ctrl_one_reg[power_control_pkg::RTC_ACCESS_UNLOCK_BIT]; // R7

    // Threshold is passed on even with the pin source; the comparator then ignores it.
    assign monitor_cfg.enable     = mon_enable; // R13
    assign monitor_cfg.source_pin = mon_ctrl_reg[power_control_pkg::MONITOR_SOURCE_BIT]; // R12
    assign monitor_cfg.threshold  = mon_ctrl_reg[power_control_pkg::MONITOR_THRESHOLD_LSB +: 3]; // R11

    // ************************************************************
    // Stop wake-up sequencer
    // ************************************************************
    power_control_pkg::wake_state_t state_reg;
    power_control_pkg::wake_state_t state_next;
    logic [7:0] wait_count_reg;
    logic [7:0] wait_count_next;
    logic [7:0] flash_cycles;

    // Flash wait selection; code 11 means no wait, software keeps off flash.
    always_comb begin
        case (flash_wait)
            2'b00:   flash_cycles = power_control_pkg::FLASH_WAIT_1_CYCLES; // R4
            2'b01:   flash_cycles = power_control_pkg::FLASH_WAIT_2_CYCLES; // R4
            2'b10:   flash_cycles = power_control_pkg::FLASH_WAIT_3_CYCLES; // R4
            default: flash_cycles = 8'h00; // R5
        endcase
    end

    // The wake delay is the regulator wait, then oscillator start (overlapping it when the immediate bit is set), then flash wait.
    always_comb begin
        state_next      = state_reg;
        wait_count_next = wait_count_reg;
        case (state_reg)
            power_control_pkg::SEQ_RUN: begin
                if (stop_request) begin
                    state_next = power_control_pkg::SEQ_STOP;
                end
            end
            power_control_pkg::SEQ_STOP: begin
                if (wake_request) begin
                    state_next = osc_immediate ? power_control_pkg::SEQ_OSCILLATOR
                                               : power_control_pkg::SEQ_REGULATOR; // R2
                end
            end
            power_control_pkg::SEQ_REGULATOR: begin
                if (main_regulator_ready) begin
                    state_next = power_control_pkg::SEQ_OSCILLATOR; // R17
                end
            end
            power_control_pkg::SEQ_OSCILLATOR: begin
                if (fast_osc_ready && (!osc_immediate || main_regulator_ready)) begin
                    state_next      = power_control_pkg::SEQ_FLASH_WAIT; // R17
                    wait_count_next = flash_cycles;
                end
            end
            power_control_pkg::SEQ_FLASH_WAIT: begin
                if (wait_count_reg == 8'h00) begin
                    state_next = power_control_pkg::SEQ_RUN; // R4
                end else begin
                    wait_count_next = wait_count_reg - 8'h01;
                end
            end
            default: begin
                state_next = power_control_pkg::SEQ_RUN;
            end
        endcase
    end

    // Sequencer state follows system reset.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg      <= power_control_pkg::SEQ_RUN;
            wait_count_reg <= 8'h00;
        end else begin
            state_reg      <= state_next;
            wait_count_reg <= wait_count_next;
        end
    end

    wire in_stop = (state_reg == power_control_pkg::SEQ_STOP);

    // In stop the low-power regulator (when its select bit is set) and stop voltage apply; otherwise main at run level.
    assign analog_ctrl.low_power_regulator      = in_stop && lp_regulator; // R3
    assign analog_ctrl.core_voltage             = in_stop ? core_voltage : 2'b00; // R6
    assign analog_ctrl.fast_osc_enable          =
        (state_reg == power_control_pkg::SEQ_RUN) ||
        (state_reg == power_control_pkg::SEQ_OSCILLATOR) ||
        (state_reg == power_control_pkg::SEQ_FLASH_WAIT); // R2
    assign analog_ctrl.main_regulator_to_active = !in_stop; // R17
    assign flash_access_allowed = (state_reg == power_control_pkg::SEQ_RUN); // R4
    assign stop_active          = (state_reg != power_control_pkg::SEQ_RUN);
    assign wake_done            = (state_reg == power_control_pkg::SEQ_FLASH_WAIT) &&
                                  (wait_count_reg == 8'h00);

    // ************************************************************
    // Monitor digital filter
    // ************************************************************
    logic [10:0] filter_len;

    // Unlisted codes 110 and 111 are both treated as the longest filter.
    always_comb begin
        case (filt_code)
            3'b000:  filter_len = 11'h001; // R9
            3'b001:  filter_len = 11'h002; // R9
            3'b010:  filter_len = 11'h004; // R9
            3'b011:  filter_len = 11'h010; // R9
            3'b100:  filter_len = 11'h040; // R9
            3'b101:  filter_len = 11'h080; // R9
            default: filter_len = power_control_pkg::FILTER_LONGEST; // R19
        endcase
    end

    // Count consecutive slow ticks at a new raw level; restart on any change.
    wire filter_hit = (filter_count_reg + 11'h001) >= filter_len;

    // The result follows power-on reset, like the status register it appears in.
    always_ff @(posedge mclk) begin
        if (por_rst) begin
            monitor_result_reg <= 1'b0;
            filter_last_reg    <= 1'b0;
            filter_count_reg   <= 11'h000;
        end else if (!mon_enable) begin
            monitor_result_reg <= 1'b0; // R13
            filter_last_reg    <= 1'b0;
            filter_count_reg   <= 11'h000;
        end else if (!filt_enable) begin
            monitor_result_reg <= monitor_raw; // R10
            filter_last_reg    <= monitor_raw;
            filter_count_reg   <= 11'h000;
        end else if (slow_clock_tick) begin
            filter_last_reg <= monitor_raw;
            if (monitor_raw == monitor_result_reg) begin
                filter_count_reg <= 11'h000;
            end else if (monitor_raw != filter_last_reg) begin
                filter_count_reg <= 11'h001;
                if (filter_len == 11'h001) begin
                    monitor_result_reg <= monitor_raw;
                    filter_count_reg   <= 11'h000;
                end
            end else if (filter_hit) begin
                monitor_result_reg <= monitor_raw; // R18
                filter_count_reg   <= 11'h000;
            end else begin
                filter_count_reg <= filter_count_reg + 11'h001;
            end
        end
    end

endmodule // power_control_voltage_monitor

`default_nettype wire

// ===== power_control_props.sv
// Checker of the bus answer, the wake sequencer and the register-driven outputs.
`timescale 1ns/10ps
`default_nettype none

module power_control_props (
    input wire logic                            mclk,
    input wire logic                            rst,
    input wire logic                            por_rst,
    input wire logic                            hsel,
    input wire logic [7:0]                      haddr,
    input wire logic [1:0]                      htrans,
    input wire logic                            hwrite,
    input wire logic [2:0]                      hsize,
    input wire logic [31:0]                     hwdata,
    input wire logic                            hready,
    input wire logic                            hreadyout,
    input wire logic                            hresp,
    input wire logic                            monitor_enable_lock,
    input wire logic                            stop_request,
    input wire logic                            stop_active,
    input wire logic                            wake_done,
    input wire logic                            flash_access_allowed,
    input wire logic                            rtc_access_allowed,
    input wire power_control_pkg::analog_ctrl_t analog_ctrl,
    input wire power_control_pkg::monitor_cfg_t monitor_cfg
);
    // ************************************************************
    // Write capture
    // ************************************************************
    // Only word writes are tracked; half-word lanes are judged by the bench.
    logic        word_wr;
    logic        wr_one_q;
    logic        wr_two_q;
    logic [31:0] wdata_q;
    assign word_wr = hsel && hready && htrans[1] && hwrite && hsize == 3'h2;

    // Flags mark the data phase; the data word is taken when the register lands.
    always_ff @(posedge mclk) begin
        wr_one_q <= !(rst || por_rst) && word_wr && haddr == 8'h00;
        wr_two_q <= !(rst || por_rst) && word_wr && haddr == 8'h04;
        wdata_q  <= hwdata;
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (rst || por_rst);

    a_bus_always_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_rtc_follows_write: assert property (wr_one_q |=> rtc_access_allowed == wdata_q[8])
        else $error("rtc access does not follow unlock write");
    a_cfg_follows_write: assert property (wr_two_q |=>
        monitor_cfg.source_pin == wdata_q[2] && monitor_cfg.threshold == wdata_q[6:4])
        else $error("monitor configuration does not follow write");
    a_lock_holds_enable: assert property (wr_two_q && monitor_enable_lock
        |=> $stable(monitor_cfg.enable))
        else $error("locked monitor enable changed");
    a_enable_when_open: assert property (wr_two_q && !monitor_enable_lock
        |=> monitor_cfg.enable == wdata_q[0])
        else $error("monitor enable ignored an open write");
    a_stop_entry_next: assert property (!stop_active && stop_request |=> stop_active)
        else $error("stop request not taken");
    a_wake_pulse_ends: assert property (wake_done |=> !wake_done && !stop_active)
        else $error("wake pulse not single or run not reached");
    a_flash_only_run: assert property ($rose(flash_access_allowed) |-> $past(wake_done))
        else $error("flash access opened without a finished flash wait");
    a_run_outputs_idle: assert property (!stop_active |-> analog_ctrl.fast_osc_enable
        && !analog_ctrl.low_power_regulator && analog_ctrl.core_voltage == 2'b00
        && analog_ctrl.main_regulator_to_active)
        else $error("regulator controls wrong in run");

    c_wake_done: cover property (wake_done);
    c_locked_write: cover property (wr_two_q && monitor_enable_lock);
    c_low_power_stop: cover property (analog_ctrl.low_power_regulator);
endmodule // power_control_props

bind power_control_voltage_monitor power_control_props props_i (.mclk, .rst, .por_rst, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .monitor_enable_lock, .stop_request, .stop_active, .wake_done, .flash_access_allowed,
    .rtc_access_allowed, .analog_ctrl, .monitor_cfg);

`default_nettype wire

// ===== tb.sv
// Self-checking testbench of the power control block.
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic        mclk, rst, por_rst, hsel, hwrite, hreadyout, hresp, monitor_enable_lock;
    logic        stop_request, wake_request, main_regulator_ready, fast_osc_ready;
    logic        slow_clock_tick, monitor_raw, flash_access_allowed, rtc_access_allowed;
    logic        stop_active, wake_done;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd, cr1_m, cr2_m, d;
    int          miscompares, checked, seed, k, n, mon_m;
    int          waits[4] = '{1000 / 50, 2000 / 50, 3000 / 50, 0};
    logic [7:0]  addrs[6] = '{8'h00, 8'h04, 8'h06, 8'h02, 8'h04, 8'h08};
    logic [2:0]  sizes[6] = '{3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h2};
    power_control_pkg::analog_ctrl_t analog_ctrl;
    power_control_pkg::monitor_cfg_t monitor_cfg;

    power_control_voltage_monitor DUT (.mclk, .rst, .por_rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .monitor_enable_lock,
        .stop_request, .wake_request, .main_regulator_ready, .fast_osc_ready, .slow_clock_tick,
        .monitor_raw, .analog_ctrl, .monitor_cfg, .flash_access_allowed, .rtc_access_allowed,
        .stop_active, .wake_done);

    // A 50 ns clock.
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report();
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // The master never assumes a latency, so a stuck bus ends the run here.
    task automatic wait_rdy();
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            miscompares++;
            final_report();
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        input logic [2:0] sz);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsize <= sz;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    // The model is updated after the transfer, once the lock level has settled.
    task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic [2:0] sz);
        logic [31:0] ln;
        xfer(1'b1, a, wd, sz);
        ln = sz == 3'h2 ? 32'hFFFFFFFF : sz != 3'h1 ? 32'h0 : a[1] ? 32'hFFFF0000 : 32'h0000FFFF;
        ln = ln & (a[7:2] == 6'h0 ? 32'h00087700 : 32'h00000F75 & ~{31'h0, monitor_enable_lock});
        if (a[7:2] == 6'h0)
            cr1_m = (cr1_m & ~ln) | (wd & ln);
        if (a[7:2] == 6'h1)
            cr2_m = (cr2_m & ~ln) | (wd & ln);
    endtask

    task automatic rd_chk(input logic [7:0] a);
        xfer(1'b0, a, 32'h0, 3'h2);
        chk($sformatf("register %h", a),
            a == 8'h00 ? cr1_m : a == 8'h04 ? cr2_m : a == 8'h14 ? 32'(mon_m) << 11 : 32'h0, rd);
    endtask

    task automatic tick(input int cnt);
        repeat (cnt) begin
            @(posedge mclk) slow_clock_tick <= 1'b1;
            @(posedge mclk) slow_clock_tick <= 1'b0;
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {hsel, hwrite, monitor_enable_lock, stop_request, wake_request} = '0;
        {slow_clock_tick, monitor_raw, haddr, htrans, hsize, hwdata} = '0;
        {rst, por_rst, main_regulator_ready, fast_osc_ready} = '1;
        seed = 32'h484df77f;
        cr1_m = 32'h00000000;
        cr2_m = 32'h00000500;
        mon_m = 0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        por_rst <= 1'b0;
        foreach (addrs[i]) rd_chk(addrs[i] == 8'h06 ? 8'h14 : addrs[i] & 8'hFC);
        // Random words through every access size, with the lock toggling.
        foreach (addrs[i]) begin
            monitor_enable_lock <= 1'($random(seed));
            wr(addrs[i], $random(seed), sizes[i]);
            rd_chk(addrs[i] & 8'hFC);
            chk("rtc access", 32'(cr1_m[8]), 32'(rtc_access_allowed));
        end
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd_chk(8'h00);
        rd_chk(8'h04);
        monitor_enable_lock <= 1'b0;
        // Stop and wake for each wait code; code 01 wakes behind a slow regulator.
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, {12'h0, 1'(c != 1), 4'h0, c[0], c[1:0], 1'b0, c[1:0], 9'h100}, 3'h2);
            @(posedge mclk) stop_request <= 1'b1;
            @(posedge mclk) stop_request <= 1'b0;
            main_regulator_ready <= c != 1;
            @(negedge mclk);
            chk("low power regulator", 32'(c[0]), 32'(analog_ctrl.low_power_regulator));
            chk("core voltage", 32'(c[1:0]), 32'(analog_ctrl.core_voltage));
            @(posedge mclk) wake_request <= 1'b1;
            @(posedge mclk) wake_request <= 1'b0;
            @(negedge mclk);
            k = 1;
            if (c == 1) begin
                repeat (4) begin
                    chk("oscillator enable", 32'h0, 32'(analog_ctrl.fast_osc_enable));
                    @(negedge mclk);
                end
                @(posedge mclk) main_regulator_ready <= 1'b1;
            end
            while (flash_access_allowed !== 1'b1 && k < 200) begin
                @(negedge mclk);
                k++;
            end
            if (c != 1)
                chk("wake cycles", waits[c] + 3, k);
            if (k >= 200)
                final_report();
        end
        // Filter of length two, then the longest code, then the bypass.
        wr(8'h04, 32'h00000301, 3'h2);
        monitor_raw <= 1'b1;
        tick(1);
        rd_chk(8'h14);
        tick(1);
        mon_m = 1;
        rd_chk(8'h14);
        wr(8'h04, 32'h00000F01, 3'h2);
        monitor_raw <= 1'b0;
        tick(1023);
        rd_chk(8'h14);
        tick(1);
        mon_m = 0;
        rd_chk(8'h14);
        d = 32'h1 | ($random(seed) & 32'h74);
        wr(8'h04, d, 3'h2);
        @(posedge mclk);
        chk("monitor cfg", {27'h0, d[0], d[2], d[6:4]}, 32'(monitor_cfg));
        repeat (4) begin
            mon_m = $random(seed) & 1;
            monitor_raw <= mon_m[0];
            rd_chk(8'h14);
        end
        // A locked write must leave the enable set while the other fields change.
        monitor_enable_lock <= 1'b1;
        wr(8'h04, 32'h00000000, 3'h2);
        rd_chk(8'h04);
        monitor_enable_lock <= 1'b0;
        wr(8'h04, 32'h00000000, 3'h2);
        monitor_raw <= 1'b1;
        mon_m = 0;
        tick(2);
        rd_chk(8'h14);
        final_report();
    end
endmodule // tb

`default_nettype wire
